/* sideband_pkg.sv */
package sideband_pkg;

  // Hardware configuration register fields (bit positions).
  localparam int CFG_W          = 8;
  localparam int CFG_REQ_POL    = 0;
  localparam int CFG_GRANT_POL  = 1;
  localparam int CFG_IRQ_POL    = 2;
  localparam int CFG_IRQ_EN     = 3;
  localparam int CFG_MERGE_IRQ  = 4;
  localparam int CFG_MERGE_DMA  = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

  // Host-side register map of the system agent.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] A_HOST_CFG  = 4'h0;
  localparam logic [ADDR_W-1:0] A_PERI_CFG  = 4'h1;
  localparam logic [ADDR_W-1:0] A_CTRL      = 4'h2;
  localparam logic [ADDR_W-1:0] A_STATUS    = 4'h3;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT  = 4'h4;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK  = 4'h5;

  // Control register bits: grant and wake requests.
  localparam int CT_HOST_GRANT = 0;
  localparam int CT_PERI_GRANT = 1;
  localparam int CT_HOST_WAKE  = 2;
  localparam int CT_PERI_WAKE  = 3;

  // Event bits of the interrupt status register.
  localparam int EV_W          = 6;
  localparam int EV_HOST_REQ   = 0;
  localparam int EV_PERI_REQ   = 1;
  localparam int EV_HOST_IRQ   = 2;
  localparam int EV_PERI_IRQ   = 3;
  localparam int EV_HOST_SUSP  = 4;
  localparam int EV_PERI_SUSP  = 5;

  // Wake pulse length driven by the agent, in cycles.
  localparam int WAKE_NS     = 1000;
  localparam int CLK_NS      = 100;
  localparam int WAKE_CYC    = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CNT_W  = 4;

endpackage : sideband_pkg

/* sideband_if.sv */
`timescale 1ns/1ps
interface sideband_if;
  logic host_dma_request;
  logic periph_dma_request;
  logic host_dma_grant;
  logic periph_dma_grant;
  logic host_irq_out;
  logic periph_irq_out;
  logic host_sleep_wake_o;
  logic host_sleep_wake_oe_n;
  logic host_sleep_wake_ext_o;
  logic host_sleep_wake_ext_oe_n;
  logic periph_sleep_wake_o;
  logic periph_sleep_wake_oe_n;
  logic periph_sleep_wake_ext_o;
  logic periph_sleep_wake_ext_oe_n;
  logic [7:0] host_hw_config_reg;
  logic [7:0] periph_hw_config_reg;
  logic host_sleep_wake_pin;
  logic periph_sleep_wake_pin;

  // Open-drain wires pulled high; any enabled low driver wins.
  assign host_sleep_wake_pin = !((!host_sleep_wake_oe_n && !host_sleep_wake_o) ||
                                 (!host_sleep_wake_ext_oe_n && !host_sleep_wake_ext_o));
  assign periph_sleep_wake_pin = !((!periph_sleep_wake_oe_n && !periph_sleep_wake_o) ||
                                   (!periph_sleep_wake_ext_oe_n && !periph_sleep_wake_ext_o));

  modport device (
    output host_dma_request, periph_dma_request, host_irq_out, periph_irq_out,
    output host_sleep_wake_o, host_sleep_wake_oe_n, periph_sleep_wake_o, periph_sleep_wake_oe_n,
    input  host_dma_grant, periph_dma_grant, host_hw_config_reg, periph_hw_config_reg,
    input  host_sleep_wake_pin, periph_sleep_wake_pin
  );
  modport agent (
    input  host_dma_request, periph_dma_request, host_irq_out, periph_irq_out,
    output host_sleep_wake_ext_o, host_sleep_wake_ext_oe_n,
    output periph_sleep_wake_ext_o, periph_sleep_wake_ext_oe_n,
    output host_dma_grant, periph_dma_grant, host_hw_config_reg, periph_hw_config_reg,
    input  host_sleep_wake_pin, periph_sleep_wake_pin
  );
endinterface : sideband_if

/* sideband_device.sv */
// Design decisions made here: three-stage input chains and merging of DMA and interrupt lines onto the host.
`timescale 1ns/1ps
module sideband_device (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  sideband_if.device  sb,
  input  wire logic   host_xfer_need,
  input  wire logic   periph_xfer_need,
  input  wire logic   host_event,
  input  wire logic   periph_event,
  input  wire logic   host_suspend_req,
  input  wire logic   periph_suspend_req,
  output logic        host_granted,
  output logic        periph_granted,
  output logic        host_suspended,
  output logic        periph_suspended,
  output logic        host_woken,
  output logic        periph_woken
);
  import sideband_pkg::*;

  typedef enum logic {
    PWR_AWAKE,
    PWR_ASLEEP
  } pwr_state_t;

  typedef struct packed {
    logic [2:0] hgnt_sync;
    logic [2:0] pgnt_sync;
    logic [2:0] hpin_sync;
    logic [2:0] ppin_sync;
    logic       hgnt;
    logic       pgnt;
    logic       hpin;
    logic       ppin;
    pwr_state_t hpwr;
    pwr_state_t ppwr;
    logic       hwoke;
    logic       pwoke;
    logic       hreq;
    logic       preq;
    logic       hirq;
    logic       pirq;
    logic       hgrant;
    logic       pgrant;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  logic [CFG_W-1:0] hcfg;
  logic [CFG_W-1:0] pcfg;
  logic             merge_dma;
  logic             merge_irq;
  logic             h_need;
  logic             p_need;
  logic             h_ev_en;
  logic             p_ev_en;
  logic             h_ev;
  logic             p_ev;
  logic             h_pin_fell;
  logic             p_pin_fell;
  logic             h_gnt_act;
  logic             p_gnt_act;

  // Settles a three-stage input once its last two stages agree.
  function automatic logic settle(input logic [2:0] sh, input logic old);
    settle = (sh[1] == sh[2]) ? sh[2] : old;
  endfunction : settle

  // Maps an active-true level to a pin level and back; pol 1 means active high.
  function automatic logic pol_map(input logic lvl, input logic pol);
    pol_map = lvl ~^ pol;
  endfunction : pol_map

  assign hcfg      = sb.host_hw_config_reg;
  assign pcfg      = sb.periph_hw_config_reg;
  assign merge_dma = hcfg[CFG_MERGE_DMA];
  assign merge_irq = hcfg[CFG_MERGE_IRQ];

  always_comb begin
    s_d = s_q;
    // Three-stage chains on the inputs driven by the far side.
    s_d.hgnt_sync = {s_q.hgnt_sync[1:0], sb.host_dma_grant};
    s_d.pgnt_sync = {s_q.pgnt_sync[1:0], sb.periph_dma_grant};
    s_d.hpin_sync = {s_q.hpin_sync[1:0], sb.host_sleep_wake_pin};
    s_d.ppin_sync = {s_q.ppin_sync[1:0], sb.periph_sleep_wake_pin};
    s_d.hgnt = settle(s_q.hgnt_sync, s_q.hgnt);
    s_d.pgnt = settle(s_q.pgnt_sync, s_q.pgnt);
    s_d.hpin = settle(s_q.hpin_sync, s_q.hpin);
    s_d.ppin = settle(s_q.ppin_sync, s_q.ppin);

    // A settled falling pin wakes a sleeping controller.
    h_pin_fell = s_q.hpin && !s_d.hpin;
    p_pin_fell = s_q.ppin && !s_d.ppin;
    s_d.hwoke  = 1'b0;
    s_d.pwoke  = 1'b0;
    unique case (s_q.hpwr)
      PWR_AWAKE: begin
        if (host_suspend_req) begin
          s_d.hpwr = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        if (h_pin_fell) begin
          s_d.hpwr  = PWR_AWAKE;
          s_d.hwoke = 1'b1;
        end
      end
    endcase
    unique case (s_q.ppwr)
      PWR_AWAKE: begin
        if (periph_suspend_req) begin
          s_d.ppwr = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        if (p_pin_fell) begin
          s_d.ppwr  = PWR_AWAKE;
          s_d.pwoke = 1'b1;
        end
      end
    endcase

    // DMA channels, optionally merged onto the host lines.
    if (merge_dma) begin
      h_need = host_xfer_need || periph_xfer_need;
      p_need = 1'b0;
    end else begin
      h_need = host_xfer_need;
      p_need = periph_xfer_need;
    end
    s_d.hreq = pol_map(h_need, hcfg[CFG_REQ_POL]);
    s_d.preq = pol_map(p_need, pcfg[CFG_REQ_POL]);

    // Interrupt lines, optionally merged onto the host line.
    h_ev_en = host_event && hcfg[CFG_IRQ_EN];
    p_ev_en = periph_event && pcfg[CFG_IRQ_EN];
    if (merge_irq) begin
      h_ev = h_ev_en || p_ev_en;
      p_ev = 1'b0;
    end else begin
      h_ev = h_ev_en;
      p_ev = p_ev_en;
    end
    s_d.hirq = pol_map(h_ev, hcfg[CFG_IRQ_POL]);
    s_d.pirq = pol_map(p_ev, pcfg[CFG_IRQ_POL]);

    // Grants, read through each controller's own polarity; under DMA merge the periph grant is the host grant while host_xfer_need is low.
    h_gnt_act = pol_map(s_q.hgnt, hcfg[CFG_GRANT_POL]);
    if (merge_dma) begin
      p_gnt_act = h_gnt_act && !host_xfer_need;
    end else begin
      p_gnt_act = pol_map(s_q.pgnt, pcfg[CFG_GRANT_POL]);
    end
    s_d.hgrant = h_gnt_act;
    s_d.pgrant = p_gnt_act;

    if (!rst_n) begin
      // Pin chains start low, since an awake controller pulls its pin low.
      s_d           = '0;
      s_d.hgnt_sync = '1;
      s_d.pgnt_sync = '1;
      s_d.hgnt      = 1'b1;
      s_d.pgnt      = 1'b1;
      s_d.hpwr      = PWR_AWAKE;
      s_d.ppwr      = PWR_AWAKE;
      s_d.hreq      = 1'b1;
      s_d.preq      = 1'b1;
      s_d.hirq      = 1'b1;
      s_d.pirq      = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // Outputs come from the state register.
  assign sb.host_dma_request       = s_q.hreq;
  assign sb.periph_dma_request     = s_q.preq;
  assign sb.host_irq_out           = s_q.hirq;
  assign sb.periph_irq_out         = s_q.pirq;
  assign sb.host_sleep_wake_o      = 1'b0;
  assign sb.host_sleep_wake_oe_n   = (s_q.hpwr == PWR_ASLEEP);
  assign sb.periph_sleep_wake_o    = 1'b0;
  assign sb.periph_sleep_wake_oe_n = (s_q.ppwr == PWR_ASLEEP);
  assign host_granted     = s_q.hgrant;
  assign periph_granted   = s_q.pgrant;
  assign host_suspended   = (s_q.hpwr == PWR_ASLEEP);
  assign periph_suspended = (s_q.ppwr == PWR_ASLEEP);
  assign host_woken       = s_q.hwoke;
  assign periph_woken     = s_q.pwoke;

endmodule : sideband_device

/* sideband_agent.sv */
`timescale 1ns/1ps
module sideband_agent (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  sideband_if.agent                        sb,
  input  wire logic [sideband_pkg::ADDR_W-1:0] addr,
  input  wire logic [sideband_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [sideband_pkg::DATA_W-1:0] rdata,
  output logic                             irq
);
  import sideband_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0]      hcfg;
    logic [CFG_W-1:0]      pcfg;
    logic [3:0]            ctrl;
    logic [2:0]            hreq_s;
    logic [2:0]            preq_s;
    logic [2:0]            hirq_s;
    logic [2:0]            pirq_s;
    logic [2:0]            hpin_s;
    logic [2:0]            ppin_s;
    logic [3:0]            lvl;
    logic [1:0]            susp;
    logic [EV_W-1:0]       stat;
    logic [EV_W-1:0]       mask;
    logic [WAKE_CNT_W-1:0] hwc;
    logic [WAKE_CNT_W-1:0] pwc;
    logic [DATA_W-1:0]     rdat;
    logic                  irq;
    logic                  hg;
    logic                  pg;
  } agent_state_t;

  agent_state_t s_q;
  agent_state_t s_d;
  logic [3:0]      lvl_n;
  logic [1:0]      susp_n;
  logic [EV_W-1:0] ev;

  function automatic logic settle(input logic [2:0] sh, input logic old);
    settle = (sh[1] == sh[2]) ? sh[2] : old;
  endfunction : settle

  always_comb begin
    s_d = s_q;
    s_d.hreq_s = {s_q.hreq_s[1:0], sb.host_dma_request};
    s_d.preq_s = {s_q.preq_s[1:0], sb.periph_dma_request};
    s_d.hirq_s = {s_q.hirq_s[1:0], sb.host_irq_out};
    s_d.pirq_s = {s_q.pirq_s[1:0], sb.periph_irq_out};
    s_d.hpin_s = {s_q.hpin_s[1:0], sb.host_sleep_wake_pin};
    s_d.ppin_s = {s_q.ppin_s[1:0], sb.periph_sleep_wake_pin};
    lvl_n[0] = settle(s_q.hreq_s, s_q.lvl[0] ^ ~s_q.hcfg[CFG_REQ_POL]) ^ ~s_q.hcfg[CFG_REQ_POL];
    lvl_n[1] = settle(s_q.preq_s, s_q.lvl[1] ^ ~s_q.pcfg[CFG_REQ_POL]) ^ ~s_q.pcfg[CFG_REQ_POL];
    lvl_n[2] = settle(s_q.hirq_s, s_q.lvl[2] ^ ~s_q.hcfg[CFG_IRQ_POL]) ^ ~s_q.hcfg[CFG_IRQ_POL];
    lvl_n[3] = settle(s_q.pirq_s, s_q.lvl[3] ^ ~s_q.pcfg[CFG_IRQ_POL]) ^ ~s_q.pcfg[CFG_IRQ_POL];
    susp_n = {settle(s_q.ppin_s, s_q.susp[1]), settle(s_q.hpin_s, s_q.susp[0])};
    s_d.lvl  = lvl_n;
    s_d.susp = susp_n;
    ev = {susp_n & ~s_q.susp, lvl_n & ~s_q.lvl};
    s_d.hg = s_q.ctrl[CT_HOST_GRANT] ~^ s_q.hcfg[CFG_GRANT_POL];
    s_d.pg = s_q.ctrl[CT_PERI_GRANT] ~^ s_q.pcfg[CFG_GRANT_POL];
    s_d.hwc = (s_q.hwc != '0) ? s_q.hwc - 1'b1 : s_q.hwc;
    s_d.pwc = (s_q.pwc != '0) ? s_q.pwc - 1'b1 : s_q.pwc;
    s_d.ctrl[CT_HOST_WAKE] = 1'b0;
    s_d.ctrl[CT_PERI_WAKE] = 1'b0;
    if (s_q.ctrl[CT_HOST_WAKE]) begin
      s_d.hwc = WAKE_CNT_W'(WAKE_CYC);
    end
    if (s_q.ctrl[CT_PERI_WAKE]) begin
      s_d.pwc = WAKE_CNT_W'(WAKE_CYC);
    end
    s_d.rdat = '0;
    if (wr) begin
      unique case (addr)
        A_HOST_CFG: s_d.hcfg = wdata;
        A_PERI_CFG: s_d.pcfg = wdata;
        A_CTRL:     s_d.ctrl = wdata[3:0];
        A_IRQ_STAT: s_d.stat = s_q.stat & ~wdata[EV_W-1:0];
        A_IRQ_MASK: s_d.mask = wdata[EV_W-1:0];
        default:    s_d.rdat = '0;
      endcase
    end
    s_d.stat = s_d.stat | ev;
    if (rd) begin
      unique case (addr)
        A_HOST_CFG: s_d.rdat = s_q.hcfg;
        A_PERI_CFG: s_d.rdat = s_q.pcfg;
        A_CTRL:     s_d.rdat = {4'h0, s_q.ctrl};
        A_STATUS:   s_d.rdat = {2'h0, s_q.susp, s_q.lvl};
        A_IRQ_STAT: s_d.rdat = {2'h0, s_q.stat};
        A_IRQ_MASK: s_d.rdat = {2'h0, s_q.mask};
        default:    s_d.rdat = '0;
      endcase
    end
    s_d.irq = |(s_d.stat & s_d.mask);
    if (!rst_n) begin
      s_d = '0;
      s_d.hcfg = CFG_RST;
      s_d.pcfg = CFG_RST;
      s_d.hg = 1'b1;
      s_d.pg = 1'b1;
      s_d.hreq_s = '1;
      s_d.preq_s = '1;
      s_d.hirq_s = '1;
      s_d.pirq_s = '1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign sb.host_hw_config_reg         = s_q.hcfg;
  assign sb.periph_hw_config_reg       = s_q.pcfg;
  assign sb.host_dma_grant             = s_q.hg;
  assign sb.periph_dma_grant           = s_q.pg;
  assign sb.host_sleep_wake_ext_o      = 1'b0;
  assign sb.host_sleep_wake_ext_oe_n   = (s_q.hwc == '0);
  assign sb.periph_sleep_wake_ext_o    = 1'b0;
  assign sb.periph_sleep_wake_ext_oe_n = (s_q.pwc == '0);
  assign rdata = s_q.rdat;
  assign irq   = s_q.irq;

endmodule : sideband_agent

/* sideband_sva.sv */
`timescale 1ns/1ps
module sideband_sva (
  input logic       clk_sys,
  input logic       rst_n,
  input logic       host_dma_request,
  input logic       periph_dma_request,
  input logic       host_irq_out,
  input logic       periph_irq_out,
  input logic       host_sleep_wake_o,
  input logic       host_sleep_wake_oe_n,
  input logic       host_sleep_wake_ext_oe_n,
  input logic       periph_sleep_wake_o,
  input logic       periph_sleep_wake_oe_n,
  input logic       periph_sleep_wake_ext_oe_n,
  input logic [7:0] host_hw_config_reg,
  input logic [7:0] periph_hw_config_reg
);
  import sideband_pkg::*;
  logic [15:0] cfg_prev_q;
  logic [3:0]  held_q;
  logic [4:0]  hlow_q;
  logic [4:0]  plow_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Tracks how long the configuration has been still and how long each wake pulse lasts.
  always_ff @(posedge clk_sys) begin
    cfg_prev_q <= {host_hw_config_reg, periph_hw_config_reg};
    held_q     <= (!rst_n || cfg_prev_q != {host_hw_config_reg, periph_hw_config_reg}) ? 4'h0
                  : held_q + {3'h0, held_q != 4'hf};
    hlow_q     <= (!rst_n || host_sleep_wake_ext_oe_n) ? 5'h00 : hlow_q + 5'h01;
    plow_q     <= (!rst_n || periph_sleep_wake_ext_oe_n) ? 5'h00 : plow_q + 5'h01;
  end
  property p_merge_dma; held_q >= 4'h4 && host_hw_config_reg[CFG_MERGE_DMA]
    |-> periph_dma_request == !periph_hw_config_reg[CFG_REQ_POL]; endproperty
  a_merge_dma: assert property (p_merge_dma) else $error("periph request active under dma merge");
  property p_merge_irq; held_q >= 4'h4 && host_hw_config_reg[CFG_MERGE_IRQ]
    |-> periph_irq_out == !periph_hw_config_reg[CFG_IRQ_POL]; endproperty
  a_merge_irq: assert property (p_merge_irq) else $error("periph irq active under irq merge");
  property p_hirq_off; held_q >= 4'h4 && !host_hw_config_reg[CFG_IRQ_EN] && !host_hw_config_reg[CFG_MERGE_IRQ]
    |-> host_irq_out == !host_hw_config_reg[CFG_IRQ_POL]; endproperty
  a_hirq_off: assert property (p_hirq_off) else $error("host irq active while disabled");
  property p_pirq_off; held_q >= 4'h4 && !periph_hw_config_reg[CFG_IRQ_EN]
    |-> periph_irq_out == !periph_hw_config_reg[CFG_IRQ_POL]; endproperty
  a_pirq_off: assert property (p_pirq_off) else $error("periph irq active while disabled");
  property p_hdrive; !host_sleep_wake_oe_n |-> !host_sleep_wake_o; endproperty
  a_hdrive: assert property (p_hdrive) else $error("host sleep pin driven high");
  property p_pdrive; !periph_sleep_wake_oe_n |-> !periph_sleep_wake_o; endproperty
  a_pdrive: assert property (p_pdrive) else $error("periph sleep pin driven high");
  property p_hwake; $fell(host_sleep_wake_ext_oe_n) && host_sleep_wake_oe_n |-> ##[1:9] !host_sleep_wake_oe_n; endproperty
  a_hwake: assert property (p_hwake) else $error("host did not leave suspend");
  property p_pwake;
    $fell(periph_sleep_wake_ext_oe_n) && periph_sleep_wake_oe_n |-> ##[1:9] !periph_sleep_wake_oe_n; endproperty
  a_pwake: assert property (p_pwake) else $error("periph did not leave suspend");
  property p_hpulse; $rose(host_sleep_wake_ext_oe_n) && $past(rst_n) |-> hlow_q == WAKE_CYC; endproperty
  a_hpulse: assert property (p_hpulse) else $error("host wake pulse length wrong");
  c_wake: cover property ($fell(periph_sleep_wake_ext_oe_n));
  c_merge: cover property (held_q >= 4'h4 && host_hw_config_reg[CFG_MERGE_DMA]);
  c_susp: cover property (host_sleep_wake_oe_n && periph_sleep_wake_oe_n);
endmodule : sideband_sva

/* tb_dma_irq_suspend_signalling.sv */
`timescale 1ns/1ps
module tb_dma_irq_suspend_signalling;
  import sideband_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic              bus_wr = 1'b0;
  logic              bus_rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic [1:0]        need = 2'h0;
  logic [1:0]        ev = 2'h0;
  logic [1:0]        susp_req = 2'h0;
  logic [1:0]        granted;
  logic [1:0]        suspended;
  logic [1:0]        woken;
  logic [3:0]        woke_h = 4'h0;
  logic [3:0]        woke_p = 4'h0;
  logic              pol;
  int                mismatches = 0;
  int                comparisons = 0;
  sideband_if        sideband_if_inst ();
  wire logic [3:0]   lines_w = {sideband_if_inst.host_dma_request, sideband_if_inst.periph_dma_request,
                                sideband_if_inst.host_irq_out, sideband_if_inst.periph_irq_out};
  wire logic [1:0]   pins_w = {sideband_if_inst.periph_sleep_wake_pin, sideband_if_inst.host_sleep_wake_pin};
  wire logic [1:0]   grants_w = {sideband_if_inst.periph_dma_grant, sideband_if_inst.host_dma_grant};
  always #50 clk_sys = ~clk_sys;
  sideband_device sideband_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sb(sideband_if_inst),
    .host_xfer_need(need[0]), .periph_xfer_need(need[1]), .host_event(ev[0]), .periph_event(ev[1]),
    .host_suspend_req(susp_req[0]), .periph_suspend_req(susp_req[1]), .host_granted(granted[0]),
    .periph_granted(granted[1]), .host_suspended(suspended[0]), .periph_suspended(suspended[1]),
    .host_woken(woken[0]), .periph_woken(woken[1]));
  sideband_agent sideband_agent_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sb(sideband_if_inst), .addr(addr),
    .wdata(wdata), .wr(bus_wr), .rd(bus_rd), .rdata(rdata), .irq(irq));
  sideband_sva sideband_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_dma_request(sideband_if_inst.host_dma_request), .periph_dma_request(sideband_if_inst.periph_dma_request),
    .host_irq_out(sideband_if_inst.host_irq_out), .periph_irq_out(sideband_if_inst.periph_irq_out),
    .host_sleep_wake_o(sideband_if_inst.host_sleep_wake_o), .host_sleep_wake_oe_n(sideband_if_inst.host_sleep_wake_oe_n),
    .host_sleep_wake_ext_oe_n(sideband_if_inst.host_sleep_wake_ext_oe_n),
    .periph_sleep_wake_o(sideband_if_inst.periph_sleep_wake_o),
    .periph_sleep_wake_oe_n(sideband_if_inst.periph_sleep_wake_oe_n),
    .periph_sleep_wake_ext_oe_n(sideband_if_inst.periph_sleep_wake_ext_oe_n),
    .host_hw_config_reg(sideband_if_inst.host_hw_config_reg),
    .periph_hw_config_reg(sideband_if_inst.periph_hw_config_reg));
  // Counts the cycles in which each wake pulse is seen.
  always @(posedge clk_sys) begin
    woke_h <= woke_h + {3'h0, woken[0] === 1'b1};
    woke_p <= woke_p + {3'h0, woken[1] === 1'b1};
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr   <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 check(rdata, e);
  endtask : reg_rd
  task automatic set_in(input logic [1:0] n, input logic [1:0] e, input logic [1:0] s);
    @(posedge clk_sys);
    need     <= n;
    ev       <= e;
    susp_req <= s;
  endtask : set_in
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_rd(A_HOST_CFG, CFG_RST);
    reg_wr(4'hf, 8'h5a);
    reg_rd(4'hf, 8'h00);
    reg_wr(A_IRQ_MASK, 8'h3f);
    idle(8);
    check({4'h0, suspended, pins_w}, 8'h00);
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      reg_wr(A_HOST_CFG, pol ? 8'h0f : 8'h08);
      reg_wr(A_PERI_CFG, pol ? 8'h0f : 8'h08);
      idle(8);
      check({4'h0, lines_w}, {4'h0, {4{~pol}}});
      reg_wr(A_IRQ_STAT, 8'h3f);
      set_in(2'h3, 2'h3, 2'h0);
      idle(8);
      check({4'h0, lines_w}, {4'h0, {4{pol}}});
      reg_rd(A_STATUS, 8'h0f);
      reg_rd(A_IRQ_STAT, 8'h0f);
      check({7'h0, irq}, 8'h01);
      reg_wr(A_IRQ_MASK, 8'h00);
      idle(2);
      check({7'h0, irq}, 8'h00);
      reg_wr(A_IRQ_MASK, 8'h3f);
      reg_wr(A_CTRL, 8'h03);
      idle(8);
      check({4'h0, grants_w, granted}, {4'h0, pol, pol, 2'h3});
      reg_wr(A_CTRL, 8'h00);
      idle(8);
      check({4'h0, grants_w, granted}, {4'h0, ~pol, ~pol, 2'h0});
      reg_wr(A_IRQ_STAT, 8'h0f);
      reg_rd(A_IRQ_STAT, 8'h00);
      check({7'h0, irq}, 8'h00);
      set_in(2'h0, 2'h0, 2'h0);
      idle(8);
    end
    reg_wr(A_HOST_CFG, 8'h38);
    reg_wr(A_PERI_CFG, 8'h08);
    set_in(2'h2, 2'h2, 2'h0);
    idle(8);
    check({4'h0, lines_w}, 8'h05);
    reg_wr(A_CTRL, 8'h01);
    idle(8);
    check({6'h0, granted}, 8'h03);
    reg_wr(A_CTRL, 8'h00);
    set_in(2'h0, 2'h0, 2'h3);
    reg_wr(A_HOST_CFG, 8'h00);
    idle(8);
    check({4'h0, suspended, pins_w}, 8'h0f);
    reg_rd(A_STATUS, 8'h30);
    set_in(2'h0, 2'h0, 2'h0);
    reg_wr(A_CTRL, 8'h0c);
    idle(20);
    check({woke_p, woke_h}, 8'h11);
    check({4'h0, suspended, pins_w}, 8'h00);
    stop_test();
  end
endmodule : tb_dma_irq_suspend_signalling
